/* hw/sta_chan.sv */
// One compare/capture module: capture, match, toggle output and PWM.
`timescale 1ns/10ps
module sta_chan (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire sta_pkg::sta_count_t count,
   input  wire logic                new_count,
   input  wire logic                low_wrap,
   input  wire sta_pkg::sta_mode_t  mode,
   input  wire logic                wr_low,
   input  wire logic                wr_high,
   input  wire sta_pkg::sta_byte_t  wdata,
   input  wire logic                pin_in,
   output sta_pkg::sta_byte_t       cmp_low,
   output sta_pkg::sta_byte_t       cmp_high,
   output logic                     event_hit,
   output logic                     match_hit,
   output logic                     pin_out,
   output logic                     pin_oe
);
   import sta_pkg::*;
   `include "sta_cfg.svh"

   sta_byte_t low_reg;
   sta_byte_t low_next;
   sta_byte_t high_reg;
   sta_byte_t high_next;
   logic      hold_reg;
   logic      hold_next;
   logic      prev_reg;
   logic      out_reg;
   logic      out_next;
   logic      oe_reg;
   logic      oe_next;
   logic      cap;
   logic      match;
   logic      pwm_mode;

   // Edge capture, match detection and next values of every register except prev_reg.
   always_comb begin
      cap = (pin_in & ~prev_reg & mode[`STA_MM_RISE_BIT]) |
            (~pin_in & prev_reg & mode[`STA_MM_FALL_BIT]); // RULE1
      pwm_mode = mode[`STA_MM_CMP_BIT] & mode[`STA_MM_PWM_BIT]; // RULE11
      match = new_count & mode[`STA_MM_CMP_BIT] & mode[`STA_MM_EQ_BIT] &
              ~hold_reg & (count == {high_reg, low_reg}); // RULE6
      low_next  = low_reg;
      high_next = high_reg;
      if (cap) begin
         low_next  = count[7:0]; // RULE2 RULE4
         high_next = count[15:8];
      end else begin
         if (wr_low) begin
            low_next = wdata;
         end else if (pwm_mode && low_wrap) begin
            low_next = high_reg; // RULE12
         end
         if (wr_high) begin
            high_next = wdata;
         end
      end
      // A low byte write suspends the comparator, a high byte write resumes.
      hold_next = hold_reg;
      if (wr_low) begin
         hold_next = 1'b1; // RULE7
      end else if (wr_high) begin
         hold_next = 1'b0;
      end
      out_next = out_reg;
      if (pwm_mode) begin
         out_next = (count[7:0] >= low_reg); // RULE10 RULE22
      end else if (match && mode[`STA_MM_FLIP_BIT]) begin
         out_next = ~out_reg; // RULE8 RULE9
      end
      oe_next = mode[`STA_MM_CMP_BIT] &
                (mode[`STA_MM_FLIP_BIT] | mode[`STA_MM_PWM_BIT]);
   end

   // Registers of the module.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_reg  <= `STA_RST_BYTE; // RULE21
         high_reg <= `STA_RST_BYTE;
         hold_reg <= 1'b0;
         prev_reg <= 1'b0;
         out_reg  <= 1'b0;
         oe_reg   <= 1'b0;
      end else begin
         low_reg  <= low_next;
         high_reg <= high_next;
         hold_reg <= hold_next;
         prev_reg <= pin_in;
         out_reg  <= out_next;
         oe_reg   <= oe_next;
      end
   end

   assign cmp_low   = low_reg;
   assign cmp_high  = high_reg;
   assign event_hit = cap | match; // RULE5
   assign match_hit = match;
   assign pin_out   = out_reg;
   assign pin_oe    = oe_reg;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_capture_load;
      cap |=> ({high_reg, low_reg} == $past(count));
   endproperty
   a_capture_load: assert property (p_capture_load) // RULE2
      else $error("Capture did not load the timer value.");

   property p_flip;
      match && mode[`STA_MM_FLIP_BIT] && !pwm_mode |=> out_reg != $past(out_reg);
   endproperty
   a_flip: assert property (p_flip) // RULE8
      else $error("Output did not invert on a match.");

   // A low byte write must leave the comparator suspended next cycle.
   property p_suspend;
      wr_low |=> hold_reg && !match;
   endproperty
   a_suspend: assert property (p_suspend) // RULE7
      else $error("Match seen while the comparator is suspended.");

   property p_reload;
      pwm_mode && low_wrap && !cap && !wr_low |=> low_reg == $past(high_reg);
   endproperty
   a_reload: assert property (p_reload) // RULE12
      else $error("Duty reload missing at the period boundary.");

   property p_pwm_level;
      pwm_mode |=> out_reg == ($past(count[7:0]) >= $past(low_reg));
   endproperty
   a_pwm_level: assert property (p_pwm_level) // RULE10
      else $error("PWM level does not follow the compare.");
endmodule

/* hw/sta_sync.sv */
// Two-flop synchroniser for the module pin inputs.
`timescale 1ns/10ps
module sta_sync (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire sta_pkg::sta_chvec_t pin_async,
   output sta_pkg::sta_chvec_t       pin_sync
);
   import sta_pkg::*;
   `include "sta_cfg.svh"

   sta_chvec_t meta_reg;
   sta_chvec_t meta_next;
   sta_chvec_t sync_reg;
   sta_chvec_t sync_next;

   // The first stage feeds only the second stage.
   always_comb begin
      meta_next = pin_async;
      sync_next = meta_reg;
   end

   // Both stages clear to zero under reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= `STA_RST_FLAGS;
         sync_reg <= `STA_RST_FLAGS;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign pin_sync = sync_reg;
endmodule

/* hw/sta_top.sv */
// Shared timer array: five compare/capture modules on one 16-bit timer.
//
// Overview of operation
// (RULE1) Either edge enable selects capture mode.
// (RULE2) Enabled pin edge copies timer into compare.
// (RULE3) Interrupt request needs event flag and enable.
// (RULE4) Later capture overwrites compare value unconditionally.
// (RULE5) Hardware sets event flag; only software clears.
// (RULE6) Comparator and match enables flag timer equality.
// (RULE7) Low byte write suspends, high resumes comparator.
// (RULE8) Flip enable inverts pin on every match.
// (RULE9) Toggle happens in hardware, repeats after wrap.
// (RULE10) PWM: low when timer byte below compare.
// (RULE11) PWM enable plus comparator enable select PWM.
// (RULE12) High byte reloads low byte at wrap.
// (RULE13) All modules share one timer time base.
// (RULE14) PWM period spans 256 low byte counts.
// (RULE15) Only module four acts as watchdog.
// (RULE16) Watchdog match raises internal reset, not pin.
// (RULE17) Clearing watchdog enable blocks the reset.
// (RULE18) Software sets watchdog enable leaving other bits.
// (RULE19) Software sets module four mode, low first.
// (RULE20) Software refreshes watchdog from main program.
// (RULE21) Each module has compare bytes resetting zero.
// (RULE22) PWM works without any interrupt enabled.
`timescale 1ns/10ps
module sta_top (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire sta_pkg::sta_chvec_t module_io_pin_in,
   output sta_pkg::sta_chvec_t       module_io_pin_out,
   output sta_pkg::sta_chvec_t       module_io_pin_oe,
   output sta_pkg::sta_chvec_t       module_irq_req,
   output logic                     wdt_reset_req
);
   import sta_pkg::*;
   `include "sta_cfg.svh"

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.
   sta_apb_state_t state_reg;
   sta_apb_state_t state_next;
   logic [31:0]    prdata_reg;
   logic [31:0]    prdata_next;
   logic           pready_reg;
   logic           pready_next;
   logic           pslverr_reg;
   logic           pslverr_next;
   logic           setup;
   logic           wr_en;
   logic           hit_any;
   sta_byte_t      rd_byte;
   sta_byte_t      wbyte;
   logic           hit_ctrl;
   logic           hit_tmode;
   logic           hit_tlow;
   logic           hit_thigh;
   logic           hit_irq;
   sta_chvec_t     hit_mm;
   sta_chvec_t     hit_cl;
   sta_chvec_t     hit_ch;
   sta_byte_t      rd_part [`STA_NUM_CH];
   sta_mode_t      mode_q  [`STA_NUM_CH];
   sta_byte_t      cl_q    [`STA_NUM_CH];
   sta_byte_t      ch_q    [`STA_NUM_CH];
   sta_chvec_t     ev;
   sta_chvec_t     match;
   sta_chvec_t     irq_en;
   sta_chvec_t     pin_sync;
   sta_count_t     count_reg;
   sta_count_t     count_next;
   logic           new_reg;
   logic           new_next;
   logic           wrap_reg;
   logic           wrap_next;
   logic           run_reg;
   logic           run_next;
   logic           wdt_en_reg;
   logic           wdt_en_next;
   sta_chvec_t     flag_reg;
   sta_chvec_t     flag_next;
   sta_chvec_t     irq_reg;
   sta_chvec_t     irq_next;
   logic           wdt_rst_reg;
   logic           wdt_rst_next;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation.
   sta_sync u_sync (
      .pclk      (pclk),
      .presetn   (presetn),
      .pin_async (module_io_pin_in),
      .pin_sync  (pin_sync)
   );

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: data and response are prepared in the setup cycle.
   assign setup     = psel & ~penable;
   assign wr_en     = psel & penable & pwrite & pready_reg;
   assign wbyte     = pwdata[7:0];
   assign hit_ctrl  = (paddr == `STA_OFF_CTRL);
   assign hit_tmode = (paddr == `STA_OFF_TMODE);
   assign hit_tlow  = (paddr == `STA_OFF_TLOW);
   assign hit_thigh = (paddr == `STA_OFF_THIGH);
   assign hit_irq   = (paddr == `STA_OFF_IRQ);
   assign hit_any   = hit_ctrl | hit_tmode | hit_tlow | hit_thigh | hit_irq |
                      (|hit_mm) | (|hit_cl) | (|hit_ch);

   // Read mux and the one-wait-free response state.
   always_comb begin
      rd_byte = 8'h00;
      if (hit_ctrl) begin
         rd_byte = {run_reg, 2'b00, flag_reg};
      end else if (hit_tmode) begin
         rd_byte = {1'b0, wdt_en_reg, 6'h00};
      end else if (hit_tlow) begin
         rd_byte = count_reg[7:0];
      end else if (hit_thigh) begin
         rd_byte = count_reg[15:8];
      end else if (hit_irq) begin
         rd_byte = {3'b000, irq_reg};
      end
      for (int i = 0; i < `STA_NUM_CH; i++) begin
         rd_byte = rd_byte | rd_part[i];
      end
      state_next   = state_reg;
      prdata_next  = prdata_reg;
      pready_next  = 1'b0;
      pslverr_next = 1'b0;
      unique case (state_reg)
         APB_IDLE: begin
            if (setup) begin
               state_next   = APB_RESP;
               pready_next  = 1'b1;
               pslverr_next = ~hit_any;
               prdata_next  = {24'h000000, rd_byte};
            end
         end
         APB_RESP: begin
            state_next = APB_IDLE;
         end
         default: begin
            state_next = APB_IDLE;
         end
      endcase
   end

   // APB response registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg   <= APB_IDLE;
         prdata_reg  <= 32'h00000000;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         state_reg   <= state_next;
         prdata_reg  <= prdata_next;
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared timer, control flags, interrupt requests and watchdog reset.
   always_comb begin
      count_next = count_reg;
      new_next   = 1'b0;
      wrap_next  = 1'b0;
      if (wr_en && hit_tlow) begin
         count_next = {count_reg[15:8], wbyte};
      end else if (wr_en && hit_thigh) begin
         count_next = {wbyte, count_reg[7:0]};
      end else if (run_reg) begin
         count_next = count_reg + 16'h0001; // RULE13 RULE14
         new_next   = 1'b1;
         wrap_next  = (count_reg[7:0] == `STA_LOW_WRAP);
      end
      run_next    = run_reg;
      wdt_en_next = wdt_en_reg;
      flag_next   = flag_reg | ev; // RULE5
      if (wr_en && hit_ctrl) begin
         run_next  = wbyte[`STA_RUN_BIT];
         flag_next = wbyte[4:0] | ev;
      end
      if (wr_en && hit_tmode) begin
         wdt_en_next = wbyte[`STA_WDT_EN_BIT]; // RULE17
      end
      irq_next     = flag_reg & irq_en; // RULE3
      wdt_rst_next = match[`STA_WDT_CH] & wdt_en_reg; // RULE15 RULE16
   end

   // Timer and control registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg   <= `STA_RST_COUNT;
         new_reg     <= 1'b0;
         wrap_reg    <= 1'b0;
         run_reg     <= 1'b0;
         wdt_en_reg  <= 1'b0;
         flag_reg    <= `STA_RST_FLAGS;
         irq_reg     <= `STA_RST_FLAGS;
         wdt_rst_reg <= 1'b0;
      end else begin
         count_reg   <= count_next;
         new_reg     <= new_next;
         wrap_reg    <= wrap_next;
         run_reg     <= run_next;
         wdt_en_reg  <= wdt_en_next;
         flag_reg    <= flag_next;
         irq_reg     <= irq_next;
         wdt_rst_reg <= wdt_rst_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-module mode registers, decode and compare/capture units.
   for (genvar i = 0; i < `STA_NUM_CH; i++) begin : g_ch
      sta_mode_t mode_reg;
      sta_mode_t mode_next;

      assign hit_mm[i] = (paddr == `STA_OFF_MMODE + `STA_REG_STEP * 8'(i));
      assign hit_cl[i] = (paddr == `STA_OFF_CLOW + `STA_REG_STEP * 8'(i));
      assign hit_ch[i] = (paddr == `STA_OFF_CHIGH + `STA_REG_STEP * 8'(i));
      assign rd_part[i] = hit_mm[i] ? {1'b0, mode_reg} :
                          hit_cl[i] ? cl_q[i] :
                          hit_ch[i] ? ch_q[i] : 8'h00;
      assign mode_q[i] = mode_reg;
      assign irq_en[i] = mode_reg[`STA_MM_IRQ_BIT];

      // Mode register next value.
      always_comb begin
         mode_next = mode_reg;
         if (wr_en && hit_mm[i]) begin
            mode_next = wbyte[6:0];
         end
      end

      // Mode register.
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            mode_reg <= `STA_RST_MODE;
         end else begin
            mode_reg <= mode_next;
         end
      end

      sta_chan u_chan (
         .pclk      (pclk),
         .presetn   (presetn),
         .count     (count_reg),
         .new_count (new_reg),
         .low_wrap  (wrap_reg),
         .mode      (mode_q[i]),
         .wr_low    (wr_en & hit_cl[i]),
         .wr_high   (wr_en & hit_ch[i]),
         .wdata     (wbyte),
         .pin_in    (pin_sync[i]),
         .cmp_low   (cl_q[i]),
         .cmp_high  (ch_q[i]),
         .event_hit (ev[i]),
         .match_hit (match[i]),
         .pin_out   (module_io_pin_out[i]),
         .pin_oe    (module_io_pin_oe[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.
   assign prdata         = prdata_reg;
   assign pready         = pready_reg;
   assign pslverr        = pslverr_reg;
   assign module_irq_req = irq_reg;
   assign wdt_reset_req  = wdt_rst_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_setup;
      psel && !penable && state_reg == APB_IDLE;
   endsequence

   property p_apb_ready;
      s_setup |=> pready_reg ##1 !pready_reg;
   endproperty
   a_apb_ready: assert property (p_apb_ready)
      else $error("APB slave did not answer in one access cycle.");

   property p_flag_set;
      (|ev) |=> ((flag_reg & $past(ev)) == $past(ev));
   endproperty
   a_flag_set: assert property (p_flag_set) // RULE5
      else $error("Event did not set its flag.");

   property p_flag_keep;
      !(wr_en && hit_ctrl) |=> ((flag_reg & $past(flag_reg)) == $past(flag_reg));
   endproperty
   a_flag_keep: assert property (p_flag_keep) // RULE5
      else $error("Flag cleared without a software write.");

   property p_irq;
      ##1 (irq_reg == $past(flag_reg & irq_en));
   endproperty
   a_irq: assert property (p_irq) // RULE3
      else $error("Interrupt request does not follow flag and enable.");

   property p_wdt_fire;
      match[`STA_WDT_CH] && wdt_en_reg |=> wdt_rst_reg ##1 !wdt_rst_reg[*1];
   endproperty
   a_wdt_fire: assert property (p_wdt_fire) // RULE16
      else $error("Watchdog match did not raise the reset request.");

   property p_wdt_block;
      !wdt_en_reg |=> !wdt_rst_reg;
   endproperty
   a_wdt_block: assert property (p_wdt_block) // RULE17
      else $error("Reset request raised with watchdog disabled.");

   property p_timer_run;
      run_reg && !(wr_en && (hit_tlow || hit_thigh))
         |=> count_reg == $past(count_reg) + 16'h0001;
   endproperty
   a_timer_run: assert property (p_timer_run) // RULE13
      else $error("Shared timer did not advance.");
endmodule

/* inc/sta_cfg.svh */
// Register offsets, field positions and reset values of the shared timer array.
`ifndef STA_CFG_SVH
`define STA_CFG_SVH

// Module count and the module that may act as watchdog.
`define STA_NUM_CH      5
`define STA_WDT_CH      4

// APB byte offsets; per-module registers step by one word.
`define STA_OFF_CTRL    8'h00
`define STA_OFF_TMODE   8'h04
`define STA_OFF_TLOW    8'h08
`define STA_OFF_THIGH   8'h0C
`define STA_OFF_MMODE   8'h10
`define STA_OFF_CLOW    8'h24
`define STA_OFF_CHIGH   8'h38
`define STA_OFF_IRQ     8'h4C
`define STA_REG_STEP    8'h04

// Field positions in timer_control_reg and timer_mode_reg.
`define STA_RUN_BIT     7
`define STA_WDT_EN_BIT  6

// Field positions in module_mode_reg.
`define STA_MM_CMP_BIT  6
`define STA_MM_RISE_BIT 5
`define STA_MM_FALL_BIT 4
`define STA_MM_EQ_BIT   3
`define STA_MM_FLIP_BIT 2
`define STA_MM_PWM_BIT  1
`define STA_MM_IRQ_BIT  0

// Reset values and the low byte value that precedes a period boundary.
`define STA_RST_BYTE    8'h00
`define STA_RST_MODE    7'h00
`define STA_RST_FLAGS   5'h00
`define STA_RST_COUNT   16'h0000
`define STA_LOW_WRAP    8'hFF

`endif

/* inc/sta_pkg.sv */
// Types shared by the shared timer array design files.
package sta_pkg;
   typedef logic [7:0]  sta_byte_t;
   typedef logic [15:0] sta_count_t;
   typedef logic [6:0]  sta_mode_t;
   typedef logic [4:0]  sta_chvec_t;
   typedef enum logic [1:0] {
      APB_IDLE = 2'b01,
      APB_RESP = 2'b10
   } sta_apb_state_t;
endpackage

/* verif/sta_pin_model.sv */
// Pin-side model that drives the module I/O pin levels.
`timescale 1ns/10ps
module sta_pin_model (
   input  wire logic          pclk,
   output sta_pkg::sta_chvec_t pin
);
   import sta_pkg::*;
   initial pin = 5'h00;
   // Changes one pin level just after a rising edge; levels then hold.
   task automatic drive(input int idx, input logic val);
      @(posedge pclk);
      pin[idx] <= val;
   endtask
endmodule

/* verif/testbench.sv */
// Self-checking bench for the shared timer array.
`timescale 1ns/10ps
`include "sta_cfg.svh"
module testbench;
   import sta_pkg::*;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   sta_chvec_t  pin_in;
   sta_chvec_t  pin_out;
   sta_chvec_t  pin_oe;
   sta_chvec_t  irq_req;
   logic        wdt_req;
   int          error_cnt;
   int          samples_checked;
   logic [31:0] rdat;
   logic [31:0] flg;
   logic        rerr;
   int          np;

   sta_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .module_io_pin_in(pin_in), .module_io_pin_out(pin_out),
      .module_io_pin_oe(pin_oe), .module_irq_req(irq_req),
      .wdt_reset_req(wdt_req));
   sta_pin_model PINS (.pclk(pclk), .pin(pin_in));

   // Free-running 20 MHz clock.
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   ////////////////////////////////////////////////////////////////////////
   // Shared helpers.
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; the request holds until pready is seen high.
   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the bench watchdog ends a wait that never sees pready.
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      xfer(1'b0, a, 32'h0);
   endtask

   function automatic logic [7:0] at(input logic [7:0] b, input int n);
      return b + 8'(4 * n);
   endfunction

   // Timer is only loaded while stopped, so captures see a fixed value.
   task automatic set_timer(input logic [15:0] v);
      wr(`STA_OFF_TLOW, {24'h0, v[7:0]});
      wr(`STA_OFF_THIGH, {24'h0, v[15:8]});
   endtask

   task automatic rd_cmp(input int n, input logic [15:0] e);
      rd(at(`STA_OFF_CLOW, n));
      chk(rdat, {24'h0, e[7:0]});
      rd(at(`STA_OFF_CHIGH, n));
      chk(rdat, {24'h0, e[15:8]});
   endtask

   // Runs the timer, counts reset pulses and returns the control word.
   task automatic run(input int cyc, output int p, output logic [31:0] f);
      p = 0;
      wr(`STA_OFF_CTRL, 32'h80);
      repeat (cyc) begin
         @(posedge pclk);
         if (wdt_req === 1'b1) p++;
      end
      rd(`STA_OFF_CTRL);
      f = rdat;
      wr(`STA_OFF_CTRL, 32'h00);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios.
   task automatic t_reset;
      for (int n = 0; n < 5; n++) rd_cmp(n, 16'h0000);
      rd(8'h50);
      chk({31'h0, rerr}, 32'h1);
      chk(rdat, 32'h0);
   endtask

   task automatic t_capture;
      wr(at(`STA_OFF_MMODE, 0), 32'h20);
      set_timer(16'h1234);
      PINS.drive(0, 1'b1);
      repeat (6) @(posedge pclk);
      rd_cmp(0, 16'h1234);
      chk(irq_req, 32'h0);
      rd(`STA_OFF_CTRL);
      chk(rdat, 32'h01);
      wr(at(`STA_OFF_MMODE, 0), 32'h21);
      repeat (2) @(posedge pclk);
      chk(irq_req, 32'h01);
      wr(`STA_OFF_CTRL, 32'h00);
      repeat (2) @(posedge pclk);
      chk(irq_req, 32'h0);
      set_timer(16'hA55A);
      PINS.drive(0, 1'b0);
      repeat (6) @(posedge pclk);
      rd_cmp(0, 16'h1234);
      wr(at(`STA_OFF_MMODE, 0), 32'h30);
      set_timer(16'h5678);
      PINS.drive(0, 1'b1);
      repeat (6) @(posedge pclk);
      rd_cmp(0, 16'h5678);
      set_timer(16'h9ABC);
      PINS.drive(0, 1'b0);
      repeat (6) @(posedge pclk);
      rd_cmp(0, 16'h9ABC);
   endtask

   task automatic t_match;
      wr(at(`STA_OFF_MMODE, 1), 32'h4C);
      wr(at(`STA_OFF_CLOW, 1), 32'h30);
      set_timer(16'h0020);
      run(40, np, flg);
      chk(flg, 32'h80);
      chk(pin_out[1], 32'h0);
      wr(at(`STA_OFF_CHIGH, 1), 32'h00);
      set_timer(16'h0020);
      run(40, np, flg);
      chk(flg, 32'h82);
      chk(pin_out[1], 32'h1);
      chk(pin_oe[1], 32'h1);
      set_timer(16'h0020);
      run(40, np, flg);
      chk(pin_out[1], 32'h0);
   endtask

   task automatic t_pwm;
      wr(at(`STA_OFF_MMODE, 2), 32'h42);
      wr(at(`STA_OFF_CHIGH, 2), 32'h40);
      rd(at(`STA_OFF_CLOW, 2));
      chk(rdat, 32'h00);
      set_timer(16'h00F0);
      run(40, np, flg);
      rd(at(`STA_OFF_CLOW, 2));
      chk(rdat, 32'h40);
      set_timer(16'h003F);
      repeat (3) @(posedge pclk);
      chk(pin_out[2], 32'h0);
      set_timer(16'h0040);
      repeat (3) @(posedge pclk);
      chk(pin_out[2], 32'h1);
      chk(pin_oe[2], 32'h1);
   endtask

   task automatic t_wdt;
      rd(`STA_OFF_TMODE);
      wr(`STA_OFF_TMODE, rdat | 32'h40);
      wr(at(`STA_OFF_MMODE, 4), 32'h4C);
      wr(at(`STA_OFF_CLOW, 4), 32'h08);
      wr(at(`STA_OFF_CHIGH, 4), 32'h00);
      set_timer(16'h0000);
      run(40, np, flg);
      chk(np, 32'h1);
      rd(`STA_OFF_TMODE);
      wr(`STA_OFF_TMODE, rdat & ~32'h40);
      set_timer(16'h0000);
      run(40, np, flg);
      chk(np, 32'h0);
      chk(flg, 32'h90);
      rd(`STA_OFF_TMODE);
      wr(`STA_OFF_TMODE, rdat | 32'h40);
      wr(at(`STA_OFF_CLOW, 4), 32'h00);
      wr(at(`STA_OFF_CHIGH, 4), 32'h01);
      set_timer(16'h0000);
      run(40, np, flg);
      chk(np, 32'h0);
      wr(at(`STA_OFF_CLOW, 4), 32'h08);
      wr(at(`STA_OFF_CHIGH, 4), 32'h00);
      set_timer(16'h0000);
      run(40, np, flg);
      chk(np, 32'h1);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence and hang guard.
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      error_cnt = 0;
      samples_checked = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_capture;
      t_match;
      t_pwm;
      t_wdt;
      report_and_stop;
   end

   initial begin
      #1000000;
      error_cnt++;
      report_and_stop;
   end
endmodule
